// ===== rtl/emi_core.sv
`default_nettype none
// Operation
// - Muxed mode shares data and low address
// - Device drives latch strobe for external latch
// - Strobe high shows address; falls holds it
// - After strobe falls, pins carry data
// - Non-muxed uses separate address, data pins
// - Map 00 on-chip, alias modulo 8 kB
// - Short form page plus pointer; long full
// - Map 01 splits at on-chip size
// - Split no-bank short leaves upper undriven
// - Long form drives all sixteen address bits
// - Map 10 short drives page high byte
// - Map 11 always off-chip
// - External-only short ignores page, upper undriven
// - Setup field bits 7:6, 0-3 cycles
// - Strobe width field plus one cycles
// - Hold field bits 1:0, 0-3 cycles
// - Access is programmed cycles plus four
// - Muxed adds latch strobe phases, min 7
// - Timing register resets to all ones
// - Mux bit clear muxed, set separate
// - Latch width field plus one per phase
// - Pins claimed only during off-chip access
// - Data drivers off during reads
module emi_core (
   input wire logic clk,
   input wire logic nrst,
   input wire logic sfr_we,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   input wire logic req,
   input wire logic req_write,
   input wire logic req_short,
   input wire logic [15:0] wide_pointer,
   input wire logic [7:0] short_pointer,
   input wire logic [7:0] req_wdata,
   output logic busy,
   output logic done,
   output logic [7:0] rdata,
   output logic ram_en,
   output logic ram_we,
   output logic [emi_pkg::EMI_RAM_AW-1:0] ram_addr,
   output logic [7:0] ram_wdata,
   input wire logic [7:0] ram_rdata,
   output logic pins_claimed,
   output logic rd_n,
   output logic wr_n,
   output logic ale,
   output logic [7:0] ad_out,
   output logic ad_oe,
   input wire logic [7:0] ad_in,
   output logic [7:0] addr_lo,
   output logic addr_lo_oe,
   output logic [7:0] addr_hi,
   output logic addr_hi_oe
);
   import emi_pkg::*;

   typedef struct packed {
      logic [7:0] timing;
      logic [4:0] config_bits;
      logic [7:0] page;
      logic [7:0] rdbk;
      emi_state_t st;
      logic [4:0] cnt;
      logic [15:0] addr;
      logic [7:0] wdat;
      logic wr;
      logic hi_drv;
      logic mux;
      logic busy;
      logic done;
      logic [7:0] rdata;
      logic ram_en;
      logic ram_we;
      logic ram_pend;
      logic claimed;
      logic rd_n;
      logic wr_n;
      logic ale;
      logic [7:0] ad_out;
      logic ad_oe;
      logic [7:0] alo;
      logic alo_oe;
      logic [7:0] ahi;
      logic ahi_oe;
   } emi_s_t;

   emi_s_t s_reg, s_next;
   logic [15:0] eff;
   logic off_chip;
   emi_map_t map;

   // True when the address lies past the on-chip RAM
   function automatic logic above_ram(input logic [15:0] a);
      above_ram = |a[15:EMI_RAM_AW];
   endfunction : above_ram

   // Effective address and target decode
   always_comb begin
      map = emi_map_t'(s_reg.config_bits[EMI_MAP_HI:EMI_MAP_LO]);
      eff = req_short ? {s_reg.page, short_pointer} : wide_pointer;
      unique case (map)
         EMI_MAP_INTERNAL: off_chip = 1'b0;
         EMI_MAP_SPLIT_NOBANK: off_chip = above_ram(eff);
         EMI_MAP_SPLIT_BANK: off_chip = above_ram(eff);
         EMI_MAP_EXTERNAL: off_chip = 1'b1;
      endcase
   end

   // Next-state logic
   always_comb begin
      s_next = s_reg;
      s_next.done = 1'b0;
      s_next.ram_en = 1'b0;
      s_next.ram_we = 1'b0;
      // Register readback
      unique case (sfr_addr)
         EMI_TIMING_ADDR: s_next.rdbk = s_reg.timing;
         EMI_CONFIG_ADDR: s_next.rdbk = {3'b000, s_reg.config_bits};
         EMI_PAGE_ADDR: s_next.rdbk = s_reg.page;
         default: s_next.rdbk = 8'h00_00;
      endcase
      if (sfr_we && !s_reg.busy) begin
         if (sfr_addr == EMI_TIMING_ADDR) begin
            s_next.timing = sfr_wdata;
         end
         if (sfr_addr == EMI_CONFIG_ADDR) begin
            s_next.config_bits = sfr_wdata[4:0];
         end
         if (sfr_addr == EMI_PAGE_ADDR) begin
            s_next.page = sfr_wdata;
         end
      end
      unique case (s_reg.st)
         EMI_ST_IDLE: begin
            if (s_reg.ram_pend) begin
               s_next.ram_pend = 1'b0;
               s_next.busy = 1'b0;
               s_next.done = 1'b1;
               if (!s_reg.wr) begin
                  s_next.rdata = ram_rdata;
               end
            end else if (req && !s_reg.busy) begin
               s_next.addr = eff;
               s_next.wdat = req_wdata;
               s_next.wr = req_write;
               s_next.busy = 1'b1;
               if (!off_chip) begin
                  s_next.ram_en = 1'b1;
                  s_next.ram_we = req_write;
                  s_next.ram_pend = 1'b1;
               end else begin
                  s_next.claimed = 1'b1;
                  s_next.mux = !s_reg.config_bits[EMI_MUX_BIT];
                  // Upper byte left to port latches on short no-bank or external
                  s_next.hi_drv = !(req_short && (map != EMI_MAP_SPLIT_BANK));
                  s_next.alo = eff[7:0];
                  s_next.alo_oe = s_reg.config_bits[EMI_MUX_BIT];
                  s_next.ahi = eff[15:8];
                  s_next.ahi_oe = s_next.hi_drv;
                  if (!s_reg.config_bits[EMI_MUX_BIT]) begin
                     s_next.st = EMI_ST_ALE_HI;
                     s_next.ale = 1'b1;
                     s_next.ad_out = eff[7:0];
                     s_next.ad_oe = 1'b1;
                     s_next.cnt = {3'b000, s_reg.config_bits[EMI_ALE_HI:EMI_ALE_LO]};
                  end else begin
                     s_next.st = EMI_ST_SETUP;
                     s_next.ad_out = req_wdata;
                     s_next.ad_oe = req_write;
                     s_next.cnt = EMI_FIXED_CYCLES - 5'h0_01 + {3'b000, s_reg.timing[EMI_SETUP_HI:EMI_SETUP_LO]};
                  end
               end
            end
         end
         EMI_ST_ALE_HI: begin
            if (s_reg.cnt == 5'h0_00) begin
               s_next.ale = 1'b0;
               s_next.st = EMI_ST_ALE_LO;
               s_next.cnt = {3'b000, s_reg.config_bits[EMI_ALE_HI:EMI_ALE_LO]};
            end else begin
               s_next.cnt = s_reg.cnt - 5'h0_01;
            end
         end
         EMI_ST_ALE_LO: begin
            if (s_reg.cnt == 5'h0_00) begin
               // Shared pins switch to data once the latch holds
               s_next.ad_out = s_reg.wdat;
               s_next.ad_oe = s_reg.wr;
               s_next.st = EMI_ST_SETUP;
               s_next.cnt = EMI_FIXED_CYCLES - 5'h0_01 + {3'b000, s_reg.timing[EMI_SETUP_HI:EMI_SETUP_LO]};
            end else begin
               s_next.cnt = s_reg.cnt - 5'h0_01;
            end
         end
         EMI_ST_SETUP: begin
            // Fixed overhead split around setup; setup counted here
            if (s_reg.cnt <= 5'h0_01) begin
               s_next.st = EMI_ST_STROBE;
               s_next.rd_n = s_reg.wr;
               s_next.wr_n = !s_reg.wr;
               s_next.cnt = {1'b0, s_reg.timing[EMI_WIDTH_HI:EMI_WIDTH_LO]};
            end else begin
               s_next.cnt = s_reg.cnt - 5'h0_01;
            end
         end
         EMI_ST_STROBE: begin
            if (s_reg.cnt == 5'h0_00) begin
               s_next.rd_n = 1'b1;
               s_next.wr_n = 1'b1;
               if (!s_reg.wr) begin
                  s_next.rdata = ad_in;
               end
               // Zero hold skips straight to the fixed release cycle
               if (s_reg.timing[EMI_HOLD_HI:EMI_HOLD_LO] == 2'b00) begin
                  s_next.st = EMI_ST_FIX;
               end else begin
                  s_next.st = EMI_ST_HOLD;
               end
               s_next.cnt = {3'b000, s_reg.timing[EMI_HOLD_HI:EMI_HOLD_LO]} - 5'h0_01;
            end else begin
               s_next.cnt = s_reg.cnt - 5'h0_01;
            end
         end
         EMI_ST_HOLD: begin
            if (s_reg.cnt == 5'h0_00) begin
               s_next.st = EMI_ST_FIX;
            end else begin
               s_next.cnt = s_reg.cnt - 5'h0_01;
            end
         end
         EMI_ST_FIX: begin
            // Release pins and finish
            s_next.st = EMI_ST_IDLE;
            s_next.claimed = 1'b0;
            s_next.ad_oe = 1'b0;
            s_next.alo_oe = 1'b0;
            s_next.ahi_oe = 1'b0;
            s_next.busy = 1'b0;
            s_next.done = 1'b1;
         end
         default: s_next.st = EMI_ST_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_reg <= '0;
         s_reg.timing <= EMI_TIMING_RST;
         s_reg.config_bits <= EMI_CONFIG_RST;
         s_reg.page <= EMI_PAGE_RST;
         s_reg.st <= EMI_ST_IDLE;
         s_reg.rd_n <= 1'b1;
         s_reg.wr_n <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   assign sfr_rdata = s_reg.rdbk;
   assign busy = s_reg.busy;
   assign done = s_reg.done;
   assign rdata = s_reg.rdata;
   assign ram_en = s_reg.ram_en;
   assign ram_we = s_reg.ram_we;
   assign ram_addr = s_reg.addr[EMI_RAM_AW-1:0];
   assign ram_wdata = s_reg.wdat;
   assign pins_claimed = s_reg.claimed;
   assign rd_n = s_reg.rd_n;
   assign wr_n = s_reg.wr_n;
   assign ale = s_reg.ale;
   assign ad_out = s_reg.ad_out;
   assign ad_oe = s_reg.ad_oe;
   assign addr_lo = s_reg.alo;
   assign addr_lo_oe = s_reg.alo_oe;
   assign addr_hi = s_reg.ahi;
   assign addr_hi_oe = s_reg.ahi_oe;

   // Strobes never both low
   property p_strobe_excl;
      @(posedge clk) disable iff (!nrst) !(!rd_n && !wr_n);
   endproperty
   a_strobe_excl: assert property (p_strobe_excl) else $error("rd and wr both low");

   // Strobe only while pins claimed
   property p_strobe_claim;
      @(posedge clk) disable iff (!nrst) (!rd_n || !wr_n) |-> pins_claimed;
   endproperty
   a_strobe_claim: assert property (p_strobe_claim) else $error("strobe outside access");

   // No data drive during a read strobe
   property p_read_float;
      @(posedge clk) disable iff (!nrst) !rd_n |-> !ad_oe;
   endproperty
   a_read_float: assert property (p_read_float) else $error("data driven during read");

   // Latch strobe never with read/write strobe
   property p_ale_excl;
      @(posedge clk) disable iff (!nrst) ale |-> (rd_n && wr_n);
   endproperty
   a_ale_excl: assert property (p_ale_excl) else $error("ale overlaps strobe");

   // Write strobe shows the write data on shared pins
   property p_wr_data;
      @(posedge clk) disable iff (!nrst) !wr_n |-> (ad_oe && ad_out == s_reg.wdat);
   endproperty
   a_wr_data: assert property (p_wr_data) else $error("write data missing");

   // Internal map never claims pins
   property p_internal;
      @(posedge clk) disable iff (!nrst)
         (req && !busy && s_reg.config_bits[EMI_MAP_HI:EMI_MAP_LO] == 2'b00) |=> !pins_claimed;
   endproperty
   a_internal: assert property (p_internal) else $error("internal map went off-chip");

   // Shortest off-chip access, with all-zero timing, spans at least 5 cycles
   property p_min_len;
      @(posedge clk) disable iff (!nrst) $rose(pins_claimed) |-> pins_claimed [*5];
   endproperty
   a_min_len: assert property (p_min_len) else $error("access too short");

   // Non-muxed access never raises the latch strobe
   property p_nomux_ale;
      @(posedge clk) disable iff (!nrst) (pins_claimed && !s_reg.mux) |-> !ale;
   endproperty
   a_nomux_ale: assert property (p_nomux_ale) else $error("ale in non-muxed");
endmodule : emi_core
`default_nettype wire

// ===== rtl/emi_pkg.sv
`default_nettype none
package emi_pkg;
   // Register map (SFR addresses)
   localparam logic [7:0] EMI_TIMING_ADDR = 8'h00_af;
   localparam logic [7:0] EMI_CONFIG_ADDR = 8'h00_ab;
   localparam logic [7:0] EMI_PAGE_ADDR = 8'h00_aa;
   // Reset values
   localparam logic [7:0] EMI_TIMING_RST = 8'h00_ff;
   localparam logic [4:0] EMI_CONFIG_RST = 5'h0_03;
   localparam logic [7:0] EMI_PAGE_RST = 8'h00_00;
   // Timing field positions
   localparam int EMI_SETUP_HI = 7;
   localparam int EMI_SETUP_LO = 6;
   localparam int EMI_WIDTH_HI = 5;
   localparam int EMI_WIDTH_LO = 2;
   localparam int EMI_HOLD_HI = 1;
   localparam int EMI_HOLD_LO = 0;
   // Config field positions
   localparam int EMI_MUX_BIT = 4;
   localparam int EMI_MAP_HI = 3;
   localparam int EMI_MAP_LO = 2;
   localparam int EMI_ALE_HI = 1;
   localparam int EMI_ALE_LO = 0;
   // Memory map modes
   typedef enum logic [1:0] {
      EMI_MAP_INTERNAL = 2'b00,
      EMI_MAP_SPLIT_NOBANK = 2'b01,
      EMI_MAP_SPLIT_BANK = 2'b10,
      EMI_MAP_EXTERNAL = 2'b11
   } emi_map_t;
   // Sequencer states
   typedef enum logic [2:0] {
      EMI_ST_IDLE = 3'b000,
      EMI_ST_ALE_HI = 3'b001,
      EMI_ST_ALE_LO = 3'b010,
      EMI_ST_SETUP = 3'b011,
      EMI_ST_STROBE = 3'b100,
      EMI_ST_HOLD = 3'b101,
      EMI_ST_FIX = 3'b110
   } emi_state_t;
   // Fixed overhead cycles of an off-chip access
   localparam logic [4:0] EMI_FIXED_CYCLES = 5'h0_04;
   // On-chip data RAM address width (8 kB)
   localparam int EMI_RAM_AW = 13;
endpackage : emi_pkg
`default_nettype wire

// ===== test/emi_ext_mem.sv
`default_nettype none
// Off-chip SRAM with a transparent low-address latch
module emi_ext_mem #(
   parameter logic [7:0] PARK = 8'hff
) (
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic ale,
   input wire logic [7:0] ad_out,
   input wire logic ad_oe,
   input wire logic [7:0] addr_lo,
   input wire logic addr_lo_oe,
   input wire logic [7:0] addr_hi,
   input wire logic addr_hi_oe,
   output logic [7:0] ad_in
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] mem [0:65535];
   logic [7:0] lat = 8'h00;
   logic [7:0] last = 8'h00;
   logic [15:0] a;
   // Latch follows the shared pins while strobe high, holds after
   always @(ale or ad_out or ad_oe) if (ale && ad_oe) lat = ad_out;
   // Undriven upper pins read as the parked port level
   assign a = {addr_hi_oe ? addr_hi : PARK, addr_lo_oe ? addr_lo : lat};
   // Write data taken as the strobe ends
   always @(posedge wr_n) if (ad_oe) mem[a] = ad_out;
   always @(posedge rd_n) last = mem[a];
   // Drive only under read strobe, else inverse of last value
   assign ad_in = rd_n ? ~last : mem[a];
endmodule : emi_ext_mem
`default_nettype wire

// ===== test/tb_top.sv
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import emi_pkg::*;
   typedef struct {
      logic [4:0] cfg;
      logic [7:0] tim;
      logic [7:0] pg;
      logic sh;
      logic [15:0] p;
      logic ext;
      logic hi;
   } emi_row_t;
   logic clk = 0, nrst = 0, sfr_we = 0, req = 0, req_write = 0, req_short = 0;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, short_pointer = 8'h00, req_wdata = 8'h00;
   logic [15:0] wide_pointer = 16'h0000;
   logic [7:0] sfr_rdata, rdata, ram_wdata, ad_out, ad_in, addr_lo, addr_hi, got, wd;
   logic [7:0] ram_rdata;
   logic [12:0] ram_addr;
   logic busy, done, ram_en, ram_we, pins_claimed, rd_n, wr_n, ale, ad_oe, addr_lo_oe, addr_hi_oe;
   logic [7:0] ram [0:8191];
   int n_fail = 0, n_tests = 0, cnt[6];
   emi_row_t rows[9] = '{
      '{5'h10, 8'h00, 8'h12, 1, 16'h0034, 0, 0}, '{5'h10, 8'hff, 8'h00, 0, 16'h4000, 0, 0},
      '{5'h14, 8'h00, 8'h00, 0, 16'h1000, 0, 0}, '{5'h14, 8'h00, 8'h00, 0, 16'h3456, 1, 1},
      '{5'h14, 8'h5a, 8'h40, 1, 16'h0022, 1, 0}, '{5'h0b, 8'h00, 8'h50, 1, 16'h0033, 1, 1},
      '{5'h0c, 8'h00, 8'h12, 1, 16'h0077, 1, 0}, '{5'h1c, 8'h3c, 8'h00, 0, 16'h0100, 1, 1},
      '{5'h09, 8'hc3, 8'h00, 0, 16'h8001, 1, 1}};
   emi_core dut (.clk, .nrst, .sfr_we, .sfr_addr, .sfr_wdata, .sfr_rdata, .req, .req_write, .req_short,
      .wide_pointer, .short_pointer, .req_wdata, .busy, .done, .rdata, .ram_en, .ram_we, .ram_addr,
      .ram_wdata, .ram_rdata, .pins_claimed, .rd_n, .wr_n, .ale, .ad_out, .ad_oe, .ad_in, .addr_lo,
      .addr_lo_oe, .addr_hi, .addr_hi_oe);
   emi_ext_mem pm (.rd_n, .wr_n, .ale, .ad_out, .ad_oe, .addr_lo, .addr_lo_oe, .addr_hi, .addr_hi_oe,
      .ad_in);
   always #2 clk = ~clk;
   // On-chip RAM, write on enable, read straight from the registered address
   always @(posedge clk) begin
      if (ram_en && ram_we) ram[ram_addr] <= ram_wdata;
   end
   assign ram_rdata = ram[ram_addr];
   // Per-access cycle counts and strobe/bus hazards
   always @(posedge clk) begin
      if (pins_claimed === 1'b1) cnt[0] <= cnt[0] + 1;
      if (rd_n === 1'b0 || wr_n === 1'b0) cnt[1] <= cnt[1] + 1;
      if (ale === 1'b1) cnt[2] <= cnt[2] + 1;
      if (ram_en === 1'b1) cnt[3] <= cnt[3] + 1;
      if (addr_hi_oe === 1'b1) cnt[4] <= cnt[4] + 1;
      if ((rd_n === 1'b0 && (wr_n !== 1'b1 || ad_oe !== 1'b0)) ||
          (wr_n === 1'b0 && (ad_oe !== 1'b1 || ad_out !== wd))) cnt[5] <= cnt[5] + 1;
   end
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task automatic chk_n(input string nm, input int e, input int g);
      n_tests++;
      if (g != e) begin
         n_fail++;
         $display("CHECK FAILED %s exp %0d got %0d", nm, e, g);
      end
   endtask : chk_n
   task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk) #1;
      sfr_we = 1;
      sfr_addr = a;
      sfr_wdata = d;
      @(posedge clk) #1;
      sfr_we = 0;
   endtask : sfr_wr
   task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk) #1;
      sfr_addr = a;
      @(posedge clk) #1;
      d = sfr_rdata;
   endtask : sfr_rd
   task automatic wait_done();
      int i;
      i = 0;
      while (done !== 1'b1 && i < 300) begin
         @(posedge clk) #1;
         i++;
      end
      chk_n("done_seen", 1, i < 300);
   endtask : wait_done
   task automatic acc(input emi_row_t r, input logic w, output logic [7:0] d);
      int al, e;
      al = r.cfg[1:0] + 1;
      e = r.tim[7:6] + r.tim[5:2] + 1 + r.tim[1:0] + 4 + (r.cfg[4] ? 0 : 2 * al);
      @(posedge clk) #1;
      cnt = '{0, 0, 0, 0, 0, 0};
      req = 1;
      req_write = w;
      req_short = r.sh;
      wide_pointer = r.p;
      short_pointer = r.p[7:0];
      req_wdata = wd;
      @(posedge clk) #1;
      req = 0;
      wait_done();
      d = rdata;
      @(posedge clk) #1;
      chk_n("claimed_cycles", r.ext ? e : 0, cnt[0]);
      chk_n("strobe_cycles", r.ext ? r.tim[5:2] + 1 : 0, cnt[1]);
      chk_n("latch_cycles", (r.ext && !r.cfg[4]) ? al : 0, cnt[2]);
      chk_n("ram_pulses", r.ext ? 0 : 1, cnt[3]);
      chk_n("upper_driven", r.ext && r.hi, cnt[4] > 0);
      chk_n("strobe_bus", 0, cnt[5]);
      chk("idle_strobes", 2'b11, {rd_n, wr_n});
   endtask : acc
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : finish_test
   initial begin
      #100000;
      n_fail++;
      finish_test();
   end
   initial begin
      logic [15:0] ea;
      repeat (2) @(posedge clk);
      #1 nrst = 1;
      // Table of map, form and timing cases: write then read back
      foreach (rows[k]) begin
         sfr_wr(EMI_CONFIG_ADDR, {3'b000, rows[k].cfg});
         sfr_wr(EMI_TIMING_ADDR, rows[k].tim);
         sfr_wr(EMI_PAGE_ADDR, rows[k].pg);
         ea = rows[k].sh ? {rows[k].pg, rows[k].p[7:0]} : rows[k].p;
         wd = 8'h5a ^ 8'(k);
         acc(rows[k], 1'b1, got);
         if (rows[k].ext) chk("ext_mem", wd, pm.mem[{rows[k].hi ? ea[15:8] : 8'hff, ea[7:0]}]);
         else chk("ram", wd, ram[ea[12:0]]);
         acc(rows[k], 1'b0, got);
         chk("read_data", wd, got);
         $display("test %0d done", k);
      end
      // Second reset: register reset values and readback
      #1 nrst = 0;
      repeat (2) @(posedge clk);
      #1 nrst = 1;
      chk("reset_strobes", 3'b110, {rd_n, wr_n, pins_claimed});
      sfr_rd(EMI_TIMING_ADDR, got);
      chk("timing_reset", EMI_TIMING_RST, got);
      sfr_rd(EMI_CONFIG_ADDR, got);
      chk("config_reset", 8'h03, got);
      sfr_rd(EMI_PAGE_ADDR, got);
      chk("page_reset", 8'h00, got);
      sfr_wr(EMI_CONFIG_ADDR, 8'hff);
      sfr_rd(EMI_CONFIG_ADDR, got);
      chk("config_unused", 8'h1f, got);
      sfr_rd(8'h00, got);
      chk("unmapped", 8'h00, got);
      $display("test reset done");
      // Timing write during a busy access is refused
      @(posedge clk) #1;
      req = 1;
      req_write = 0;
      req_short = 0;
      wide_pointer = 16'h0100;
      @(posedge clk) #1;
      req = 0;
      sfr_wr(EMI_TIMING_ADDR, 8'h00);
      wait_done();
      sfr_rd(EMI_TIMING_ADDR, got);
      chk("busy_write", 8'hff, got);
      $display("test busy done");
      finish_test();
   end
endmodule : tb_top
`default_nettype wire
